// [dv/bpd_backlight_ctl_props.sv]
// checker for the backlight pulse dimming control ports
`timescale 1ns/1ns
module bpd_backlight_ctl_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic boost_overvoltage_sense,
  input wire logic input_uvlo,
  input wire logic input_ovlo,
  input wire logic system_rail_uvlo,
  input wire logic temp_above_120c,
  input wire logic temp_above_165c,
  input wire logic main_rail_feedback,
  input wire logic backlight_boost,
  input wire logic [4:0] boost_feedback,
  input wire logic boost_soft_start,
  input wire logic main_buck,
  input wire logic charger_on,
  input wire logic led_sinks_on,
  input wire logic input_switch_on,
  input wire logic battery_switch_on,
  input wire logic charge_indicator_n_oe,
  input wire logic main_rail_reset_n_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // protection gating; three cycles allow for the registered outputs
  chk_rail_uv_off: assert property (system_rail_uvlo [*3] |->
    !main_buck && !led_sinks_on && !charger_on) else $error("rail uvlo left outputs on");
  chk_rail_uv_rst: assert property (system_rail_uvlo [*3] |->
    main_rail_reset_n_oe && !charge_indicator_n_oe) else $error("rail uvlo pins wrong");
  chk_in_uv_iso: assert property (input_uvlo [*3] |->
    !input_switch_on && battery_switch_on && !charger_on) else $error("input uvlo not isolated");
  chk_in_ov_iso: assert property (input_ovlo [*3] |->
    !input_switch_on && !charger_on && !charge_indicator_n_oe) else $error("ovlo not isolated");
  chk_hot_off: assert property (temp_above_165c [*3] |->
    !main_buck && !backlight_boost && !charger_on) else $error("hot shutdown missed");
  chk_warm_no_input: assert property (temp_above_120c [*3] |-> !input_switch_on)
    else $error("input drawn while hot");
  chk_ovp_latch: assert property ($rose(boost_overvoltage_sense) |-> ##[1:3] !backlight_boost)
    else $error("overvoltage did not stop boost");
  // while on, the level only holds or falls by one; no wrap at the floor
  chk_dim_step: assert property (backlight_boost && $past(backlight_boost, 3) |->
    boost_feedback == $past(boost_feedback) ||
    {1'b0, boost_feedback} == {1'b0, $past(boost_feedback)} - 6'h01)
    else $error("brightness level jumped");
  chk_boost_soft: assert property ($rose(backlight_boost) |-> ##[0:1] boost_soft_start)
    else $error("boost without soft start");
  chk_dip_filter: assert property ($fell(main_rail_feedback) && !main_rail_reset_n_oe &&
    !system_rail_uvlo |-> !main_rail_reset_n_oe [*8]) else $error("short dip hit reset");
endmodule
bind bpd_backlight_ctl bpd_backlight_ctl_props i_bpd_backlight_ctl_props (.*);

// [dv/bpd_host_model.sv]
// host model that drives the backlight control line
`timescale 1ns/1ns
module bpd_host_model (
  input wire logic clk_sys,
  output logic backlight_ctl_line
);
  initial backlight_ctl_line = 1'b0;
  // hold a level for n samples; the width alone picks on, off or one dim step
  task automatic drive(input logic lvl, input int n);
    @(posedge clk_sys);
    #2 backlight_ctl_line = lvl;
    repeat (n - 1) @(posedge clk_sys);
    #2;
  endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench for the backlight pulse dimming control
`timescale 1ns/1ns
module tb_top;
  logic clk_sys, rst_n, backlight_ctl_line, boost_overvoltage_sense, input_uvlo, input_ovlo;
  logic system_rail_uvlo, temp_above_100c, temp_above_120c, temp_above_165c, temp_cooled_15c;
  logic buck_group_enable, charger_enable, charge_active, main_rail_feedback;
  logic [5:0] temp_excess_deg;
  logic backlight_boost, boost_soft_start, main_buck, buck_soft_start, charger_on, led_sinks_on;
  logic input_switch_on, battery_switch_on, charge_limit_cut, charge_indicator_n_out;
  logic charge_indicator_n_oe, main_rail_reset_n_out, main_rail_reset_n_oe;
  logic [4:0] boost_feedback;
  logic [6:0] input_limit_pct;
  int miscompares = 0;
  int compares = 0;
  // small off and release counts keep the run short
  bpd_backlight_ctl #(.OFF_CYCLES(20), .RST_REL_CYCLES(50)) i_bpd_backlight_ctl (.*);
  bpd_host_model i_bpd_host_model (.clk_sys(clk_sys), .backlight_ctl_line(backlight_ctl_line));
  always #20 clk_sys = ~clk_sys;
  // ==========================================================
  // helpers
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic cmp(input string n, input logic [6:0] e, input logic [6:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic lvl(input logic [4:0] e);
    wt(3);
    cmp("level", {2'h0, e}, {2'h0, boost_feedback});
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_dimming;
    i_bpd_host_model.drive(1'b1, 2400);
    cmp("boost early", 7'h00, {6'h00, backlight_boost});
    i_bpd_host_model.drive(1'b1, 200);
    lvl(5'h1f);
    for (int i = 0; i < 3; i++) begin
      i_bpd_host_model.drive(1'b0, 15);
      i_bpd_host_model.drive(1'b1, 10);
    end
    lvl(5'h1c);
    i_bpd_host_model.drive(1'b0, 5);
    i_bpd_host_model.drive(1'b1, 10);
    lvl(5'h1c);
    for (int i = 0; i < 29; i++) begin
      i_bpd_host_model.drive(1'b0, 13);
      i_bpd_host_model.drive(1'b1, 1);
    end
    lvl(5'h00);
    cmp("boost at floor", 7'h01, {6'h00, backlight_boost});
    i_bpd_host_model.drive(1'b0, 25);
    wt(3);
    cmp("boost off", 7'h00, {6'h00, backlight_boost});
    i_bpd_host_model.drive(1'b1, 2600);
    lvl(5'h1f);
    $display("test dimming done");
  endtask
  task automatic t_overvoltage;
    boost_overvoltage_sense = 1'b1;
    wt(4);
    cmp("boost ovp", 7'h00, {6'h00, backlight_boost});
    boost_overvoltage_sense = 1'b0;
    wt(30);
    cmp("boost latched", 7'h00, {6'h00, backlight_boost});
    i_bpd_host_model.drive(1'b0, 25);
    i_bpd_host_model.drive(1'b1, 2600);
    wt(3);
    cmp("boost relit", 7'h01, {6'h00, backlight_boost});
    $display("test overvoltage done");
  endtask
  task automatic t_supply;
    charge_active = 1'b1;
    wt(4);
    cmp("charging", 7'h03, {5'h00, charger_on, charge_indicator_n_oe});
    input_uvlo = 1'b1;
    wt(4);
    cmp("uv switches", 7'h01, {5'h00, input_switch_on, battery_switch_on});
    cmp("uv charge", 7'h00, {5'h00, charger_on, charge_indicator_n_oe});
    cmp("uv runs", 7'h03, {5'h00, main_buck, led_sinks_on});
    input_uvlo = 1'b0;
    input_ovlo = 1'b1;
    wt(4);
    cmp("ov pins", 7'h00, {4'h0, input_switch_on, charger_on, charge_indicator_n_oe});
    input_ovlo = 1'b0;
    wt(4);
    cmp("ov resume", 7'h03, {5'h00, input_switch_on, charger_on});
    main_rail_feedback = 1'b1;
    wt(40);
    cmp("reset held", 7'h01, {6'h00, main_rail_reset_n_oe});
    wt(20);
    cmp("reset freed", 7'h00, {6'h00, main_rail_reset_n_oe});
    main_rail_feedback = 1'b0;
    wt(5);
    main_rail_feedback = 1'b1;
    wt(3);
    cmp("dip ignored", 7'h00, {6'h00, main_rail_reset_n_oe});
    system_rail_uvlo = 1'b1;
    wt(4);
    cmp("rail uv", 7'h00, {4'h0, main_buck, led_sinks_on, charger_on});
    cmp("rail pins", 7'h40, {main_rail_reset_n_oe, charge_indicator_n_oe, 5'h00});
    cmp("pin levels", 7'h00, {5'h00, main_rail_reset_n_out, charge_indicator_n_out});
    system_rail_uvlo = 1'b0;
    $display("test supply done");
  endtask
  task automatic t_thermal;
    cmp("limit cool", 7'h64, input_limit_pct);
    temp_above_100c = 1'b1;
    temp_excess_deg = 6'h04;
    wt(4);
    cmp("limit pct", 7'h50, input_limit_pct);
    cmp("charge cut", 7'h01, {6'h00, charge_limit_cut});
    temp_excess_deg = 6'h19;
    wt(4);
    cmp("limit floor", 7'h00, input_limit_pct);
    temp_above_120c = 1'b1;
    wt(4);
    cmp("no input", 7'h00, {6'h00, input_switch_on});
    temp_above_165c = 1'b1;
    wt(4);
    cmp("hot off", 7'h00, {4'h0, main_buck, backlight_boost, charger_on});
    {temp_above_100c, temp_above_120c, temp_above_165c, temp_cooled_15c} = 4'h1;
    wt(4);
    cmp("cool restart", 7'h07, {4'h0, main_buck, buck_soft_start, charger_on});
    cmp("cool boost", 7'h03, {5'h00, backlight_boost, boost_soft_start});
    temp_cooled_15c = 1'b0;
    $display("test thermal done");
  endtask
  initial begin
    {clk_sys, rst_n, boost_overvoltage_sense, input_uvlo, input_ovlo, system_rail_uvlo} = 6'h00;
    {temp_above_100c, temp_above_120c, temp_above_165c, temp_cooled_15c} = 4'h0;
    {charge_active, main_rail_feedback} = 2'h0;
    {buck_group_enable, charger_enable} = 2'h3;
    temp_excess_deg = 6'h00;
    repeat (5) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    wt(3);
    t_dimming();
    t_overvoltage();
    t_supply();
    t_thermal();
    end_sim();
  end
  // watchdog sized well beyond the roughly 8.5k cycles the tests need
  initial begin
    #(40 * 40000);
    miscompares++;
    end_sim();
  end
endmodule

// [verilog/bpd_backlight_ctl.sv]
// backlight pulse dimming control with supply and thermal protection gating
`timescale 1ns/1ns
// ==========================================================
// Summary of operation
// [R1] high 100us powers boost at full scale
// [R2] low 2ms disables the boost
// [R3] low pulse 500ns..500us is one step
// [R4] each step lowers target by 1/32
// [R5] 32 linear steps; else plain enable
// [R6] overvoltage latches off until 2ms low
// [R7] input undervoltage: battery feeds rail, charger off
// [R8] input undervoltage keeps regulators and sinks running
// [R9] input overvoltage: isolate input, charger off
// [R10] input back in range resumes normal use
// [R11] rail undervoltage disables regulators, sinks, charger
// [R12] rail undervoltage: indicator released, reset asserted
// [R13] above 100C cut limit 5%/C, charge first
// [R14] at 120C draw nothing from input
// [R15] above 165C disable regulators and charger
// [R16] after cooling, resume enables with soft-start
// [R17] every regulator soft-starts at power-up
// [R18] feedback dips under 50us ignored for reset
// [R19] release reset 200ms after feedback good
// [R20] free-running time base; mid-length lows ignored
// [R21] dimming stops at lowest step, no wrap
// ==========================================================
// every level is timed in clk_sys cycles by one counter that restarts at
// each edge of the control line, so on, off and dim are told apart only by
// how long the last level lasted; the off and release counts are parameters
// so a bench can shrink them, while the real values come from the package
module bpd_backlight_ctl #(
  parameter int unsigned OFF_CYCLES = bpd_pkg::OFF_CYC,
  parameter int unsigned RST_REL_CYCLES = bpd_pkg::RST_REL_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic backlight_ctl_line,
  input wire logic boost_overvoltage_sense,
  input wire logic input_uvlo,
  input wire logic input_ovlo,
  input wire logic system_rail_uvlo,
  input wire logic temp_above_100c,
  input wire logic [5:0] temp_excess_deg,
  input wire logic temp_above_120c,
  input wire logic temp_above_165c,
  input wire logic temp_cooled_15c,
  input wire logic buck_group_enable,
  input wire logic charger_enable,
  input wire logic charge_active,
  input wire logic main_rail_feedback,
  output logic backlight_boost,
  output logic [4:0] boost_feedback,
  output logic boost_soft_start,
  output logic main_buck,
  output logic buck_soft_start,
  output logic charger_on,
  output logic led_sinks_on,
  output logic input_switch_on,
  output logic battery_switch_on,
  output logic [6:0] input_limit_pct,
  output logic charge_limit_cut,
  output logic charge_indicator_n_out,
  output logic charge_indicator_n_oe,
  output logic main_rail_reset_n_out,
  output logic main_rail_reset_n_oe
);

  // ==========================================================
  // reset release
  // two flops so every register leaves reset on one clean edge; only the
  // second flop is read
  logic [1:0] rst_sync_reg;
  logic rst_int_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'h1};
  end
  assign rst_int_n = rst_sync_reg[1];

  // ==========================================================
  // line timing: one counter, restarted at every edge of the line
  // line_reg resets low, the idle level of the line, so no false rise follows reset
  logic line_reg, line_next;
  logic [bpd_pkg::CNT_W-1:0] run_reg, run_next;
  logic rise, long_low;
  always_comb begin
    line_next = backlight_ctl_line;
    rise = backlight_ctl_line && !line_reg;
    // saturate so a long level never wraps the measurement [R20]
    if (backlight_ctl_line != line_reg) run_next = '0;
    else if (&run_reg) run_next = run_reg;
    else run_next = run_reg + 1'b1;
  end
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      line_reg <= 1'h0;
      run_reg <= '0;
    end else begin
      line_reg <= line_next;
      run_reg <= run_next;
    end
  end
  // the same long low that shuts the boost down also clears the latch
  assign long_low = !line_reg && run_reg >= OFF_CYCLES[bpd_pkg::CNT_W-1:0] - 1'b1; // [R2]

  // ==========================================================
  // boost state, brightness and overvoltage latch
  bpd_pkg::bpd_state_t st_reg, st_next;
  logic [4:0] lvl_reg, lvl_next;
  logic [bpd_pkg::CNT_W-1:0] low_len;
  always_comb begin
    st_next = st_reg;
    lvl_next = lvl_reg;
    // low_len is the length of the low level that the current rise ends
    low_len = run_reg + 1'b1;
    case (st_reg)
      bpd_pkg::BPD_OFF: begin
        if (line_reg && run_reg >= bpd_pkg::ON_CYC - 1) begin
          st_next = bpd_pkg::BPD_ON; // [R1]
          lvl_next = bpd_pkg::LEVEL_FULL; // [R1]
        end
      end
      bpd_pkg::BPD_ON: begin
        // off is tested first so a shutdown low wins over a late overvoltage
        if (long_low) st_next = bpd_pkg::BPD_OFF; // [R2]
        else if (boost_overvoltage_sense) st_next = bpd_pkg::BPD_LATCHED; // [R6]
        else if (rise && low_len >= bpd_pkg::DIM_MIN_CYC
                 && low_len <= bpd_pkg::DIM_MAX_CYC) begin
          // pulses between dim range and shutdown change nothing [R20]
          if (lvl_reg != bpd_pkg::LEVEL_MIN) lvl_next = lvl_reg - 1'b1; // [R3] [R4] [R21]
        end
      end
      bpd_pkg::BPD_LATCHED: begin
        // only a full shutdown low clears the latch [R6]
        if (long_low) st_next = bpd_pkg::BPD_OFF;
      end
      default: st_next = bpd_pkg::BPD_OFF;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      st_reg <= bpd_pkg::BPD_OFF;
      lvl_reg <= bpd_pkg::LEVEL_FULL;
    end else begin
      st_reg <= st_next;
      lvl_reg <= lvl_next;
    end
  end

  // ==========================================================
  // protection gating
  logic regs_ok, input_ok;
  always_comb begin
    // regs_ok also gates the led sinks, which run from the battery under input lockout
    regs_ok = !system_rail_uvlo && !temp_above_165c; // [R8] [R11] [R15]
    // input use resumes as soon as the lockout flags clear [R10]
    // 120c isolates the input only; the rail keeps running from the battery
    input_ok = !input_uvlo && !input_ovlo && !temp_above_120c; // [R7] [R9] [R14]
  end

  // thermal shutdown is held until the die has cooled by the hysteresis
  logic hot_reg, hot_next;
  always_comb begin
    hot_next = hot_reg;
    // the set wins when overtemperature and the cooled flag meet in one cycle
    if (temp_above_165c) hot_next = 1'h1; // [R15]
    else if (temp_cooled_15c) hot_next = 1'h0; // [R16]
  end
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) hot_reg <= 1'h0;
    else hot_reg <= hot_next;
  end

  // regulators may run only with the rail good and no thermal shutdown held
  function automatic logic run_ok(input logic rail_ok, input logic hot);
    run_ok = rail_ok && !hot;
  endfunction

  // ==========================================================
  // soft-start timers restart whenever a regulator is re-enabled
  logic boost_run, buck_run;
  logic [1:0] run_en;
  logic [1:0] ss_active;
  assign boost_run = st_reg == bpd_pkg::BPD_ON && run_ok(regs_ok, hot_reg);
  assign buck_run = buck_group_enable && run_ok(regs_ok, hot_reg);
  assign run_en = {buck_run, boost_run};
  // a regulator that drops out for even one cycle ramps again from zero [R16]
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_soft
      // 16 bits hold the ramp count with room to spare
      logic [15:0] ss_reg, ss_next;
      always_comb begin
        if (!run_en[gi]) ss_next = '0; // [R16] [R17]
        else if (ss_reg < bpd_pkg::SOFT_CYC) ss_next = ss_reg + 1'b1;
        else ss_next = ss_reg;
      end
      always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) ss_reg <= '0;
        else ss_reg <= ss_next;
      end
      assign ss_active[gi] = run_en[gi] && ss_reg < bpd_pkg::SOFT_CYC; // [R17]
    end
  endgenerate

  // ==========================================================
  // thermal input current limit: 5% per degree above 100C, floor 0
  // charge current is cut first, so the system load keeps what is left
  function automatic logic [6:0] limit_pct(input logic hot, input logic [5:0] deg);
    logic [8:0] cut;
    cut = 9'(deg) * 9'h005;
    if (!hot) limit_pct = 7'h64;
    else if (cut >= 9'h064) limit_pct = 7'h00;
    else limit_pct = 7'(9'h064 - cut);
  endfunction

  // ==========================================================
  // reset output: deglitch falling feedback, delayed release
  // rail undervoltage forces reset at once, bypassing the dip filter
  logic fb_ok_reg, fb_ok_next;
  logic [bpd_pkg::CNT_W-1:0] fb_cnt_reg, fb_cnt_next;
  logic rstn_reg, rstn_next;
  always_comb begin
    fb_ok_next = fb_ok_reg;
    fb_cnt_next = fb_cnt_reg;
    rstn_next = rstn_reg;
    if (system_rail_uvlo || !main_rail_feedback && fb_ok_reg
        && fb_cnt_reg >= bpd_pkg::DEGLITCH_CYC - 1) begin
      fb_ok_next = 1'h0; // [R12] [R18]
      fb_cnt_next = '0;
      rstn_next = 1'h0;
    end else if (main_rail_feedback != fb_ok_reg) begin
      // count how long the feedback has disagreed with the filtered state
      // a dip restarts the count, trading a later release for no chatter
      fb_cnt_next = fb_cnt_reg + 1'b1; // [R18]
      if (main_rail_feedback && fb_cnt_reg >= RST_REL_CYCLES[bpd_pkg::CNT_W-1:0] - 1'b1) begin
        fb_ok_next = 1'h1;
        fb_cnt_next = '0;
        rstn_next = 1'h1; // [R19]
      end
    end else fb_cnt_next = '0;
  end
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      fb_ok_reg <= 1'h0;
      fb_cnt_reg <= '0;
      rstn_reg <= 1'h0;
    end else begin
      fb_ok_reg <= fb_ok_next;
      fb_cnt_reg <= fb_cnt_next;
      rstn_reg <= rstn_next;
    end
  end

  // ==========================================================
  // registered outputs
  // word, msb first: boost, boost soft-start, buck, buck soft-start, charger,
  // sinks, input switch, battery switch, limit[6:0], charge cut,
  // indicator enable, level[4:0], reset enable
  // every pin but the two tied-low open-drain levels comes from one register so all outputs move on one edge
  logic [22:0] out_reg, out_next;
  logic chg_run;
  always_comb begin
    chg_run = charger_enable && input_ok && run_ok(regs_ok, hot_reg); // [R7] [R9] [R11] [R15]
    out_next = {
      boost_run, // [R1] [R2] [R6]
      ss_active[0],
      buck_run, // [R11] [R15]
      ss_active[1],
      chg_run,
      regs_ok, // [R8] [R11]
      input_ok, // [R7] [R9] [R14]
      !input_ok, // [R7] [R9] [R14]
      limit_pct(temp_above_100c, temp_excess_deg), // [R13]
      temp_above_100c, // [R13] charge is cut before system load
      chg_run && charge_active, // indicator pulls low only while charging [R12]
      (st_reg == bpd_pkg::BPD_OFF) ? bpd_pkg::LEVEL_FULL : lvl_reg, // [R5]
      !rstn_reg
    };
  end
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) out_reg <= bpd_pkg::OUT_RST;
    else out_reg <= out_next;
  end
  assign backlight_boost = out_reg[22];
  assign boost_soft_start = out_reg[21];
  assign main_buck = out_reg[20];
  assign buck_soft_start = out_reg[19];
  assign charger_on = out_reg[18];
  assign led_sinks_on = out_reg[17];
  assign input_switch_on = out_reg[16];
  assign battery_switch_on = out_reg[15];
  assign input_limit_pct = out_reg[14:8];
  assign charge_limit_cut = out_reg[7];
  // open-drain pins: the level stays low and only the enable moves
  assign charge_indicator_n_oe = out_reg[6];
  assign charge_indicator_n_out = 1'h0;
  assign boost_feedback = out_reg[5:1];
  assign main_rail_reset_n_oe = out_reg[0];
  assign main_rail_reset_n_out = 1'h0;

endmodule

// [verilog/bpd_pkg.sv]
// package of constants for the backlight pulse dimming control block
package bpd_pkg;
  // clock rate in kHz and derived cycle counts
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned T_ON_US = 100;
  localparam int unsigned T_OFF_US = 2000;
  localparam int unsigned T_DIM_MIN_NS = 500;
  localparam int unsigned T_DIM_MAX_US = 500;
  localparam int unsigned T_DEGLITCH_US = 50;
  localparam int unsigned T_RST_REL_MS = 200;
  // least times round up, longest round down
  localparam int unsigned ON_CYC = (T_ON_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned OFF_CYC = (T_OFF_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned DIM_MIN_CYC = (T_DIM_MIN_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned DIM_MAX_CYC = (T_DIM_MAX_US * CLK_KHZ) / 1000;
  localparam int unsigned DEGLITCH_CYC = (T_DEGLITCH_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned RST_REL_CYC = T_RST_REL_MS * CLK_KHZ;
  // brightness: 32 steps, full scale is step 31
  localparam int unsigned LEVEL_W = 5;
  localparam logic [4:0] LEVEL_FULL = 5'h1f;
  localparam logic [4:0] LEVEL_MIN = 5'h00;
  localparam int unsigned CNT_W = 24;
  // output word at reset: limit 100%, level at full scale, reset pin pulled low
  localparam logic [22:0] OUT_RST = 23'h00643f;
  // soft-start ramp length in cycles
  localparam int unsigned T_SOFT_US = 100;
  localparam int unsigned SOFT_CYC = (T_SOFT_US * CLK_KHZ + 999) / 1000;
  // boost state machine
  typedef enum logic [1:0] {
    BPD_OFF = 2'h0,
    BPD_ON = 2'h1,
    BPD_LATCHED = 2'h2
  } bpd_state_t;
endpackage
